// file: core/slg_game.v
// Contract
// - The selector rotates its single active bit by one position on every rising clock edge.
// - Both rising and falling edges of the select switch each become one selection pulse.
// - Each selection pulse before the zero is complete stores the indicated segment in memory, and it then stays lit until the zero is complete.
// - Reset loads the selector with exactly one set bit and clears the selection memory.
// - Segment outputs are decoded combinationally from selector, memory and completed flag; the dot is the completed flag register.
// - Once all six segments are selected, the next clock shows only the dot segment.
`timescale 1ns/1ps
`include "slg_regs.vh"

module slg_game
(
    // clock and reset
    input  wire clk,
    input  wire sys_rst,
    // player switch
    input  wire select,
    // display segments
    output wire segment_out_one,
    output wire segment_out_two,
    output wire segment_out_three,
    output wire segment_out_four,
    output wire segment_out_five,
    output wire segment_out_six,
    output wire dot_segment_out
);

    // reset patterns, handed to the cells bit by bit, and the target pattern
    localparam [`SLG_WIDTH-1:0] SEL_RST = `SLG_SEL_RESET;
    localparam [`SLG_WIDTH-1:0] MEM_RST = `SLG_MEM_RESET;
    localparam [`SLG_WIDTH-1:0] ZERO    = `SLG_ALL_LIT;

    // switch history
    reg                   sync1_q;  // synchroniser, first stage
    reg                   sync2_q;  // synchroniser, second stage
    reg                   prev_q;   // last synchronised level
    wire                  pick;     // selection pulse
    wire                  take;     // pick still counted

    // game state, one ring and one memory bit per segment
    reg                   done_q;   // zero completed
    wire                  done_d;   // next completed flag
    wire [`SLG_WIDTH-1:0] ring;
    wire [`SLG_WIDTH-1:0] stored;

    // switch synchroniser and last level, left out of reset:
    // a switch held high through reset is no toggle
    always @(posedge clk)
    begin
        sync1_q <= select;
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
    end

    // either switch edge gives one pulse, none counted after the zero
    assign pick = sync2_q ^ prev_q;
    assign take = pick & ~done_q;

    // completed flag rises one clock after the zero forms
    assign done_d = done_q | (stored == ZERO);

    // completed flag, held until reset
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            done_q <= `SLG_DONE_RESET;
        else
            done_q <= done_d;
    end

    // dot alone once the zero is complete
    assign dot_segment_out = done_q;

    // segment one, closing the ring from segment six
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[0]),
        .MEM_INIT (MEM_RST[0])
    )
    i_slg_seg_one
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[5]),
        .ring_out (ring[0]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[0]),
        .drive    (segment_out_one)
    );

    // segment two
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[1]),
        .MEM_INIT (MEM_RST[1])
    )
    i_slg_seg_two
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[0]),
        .ring_out (ring[1]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[1]),
        .drive    (segment_out_two)
    );

    // segment three
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[2]),
        .MEM_INIT (MEM_RST[2])
    )
    i_slg_seg_three
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[1]),
        .ring_out (ring[2]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[2]),
        .drive    (segment_out_three)
    );

    // segment four
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[3]),
        .MEM_INIT (MEM_RST[3])
    )
    i_slg_seg_four
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[2]),
        .ring_out (ring[3]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[3]),
        .drive    (segment_out_four)
    );

    // segment five
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[4]),
        .MEM_INIT (MEM_RST[4])
    )
    i_slg_seg_five
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[3]),
        .ring_out (ring[4]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[4]),
        .drive    (segment_out_five)
    );

    // segment six, feeding segment one
    slg_seg_cell
    #(
        .SEL_INIT (SEL_RST[5]),
        .MEM_INIT (MEM_RST[5])
    )
    i_slg_seg_six
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ring_in  (ring[4]),
        .ring_out (ring[5]),
        .take     (take),
        .blank    (done_q),
        .stored   (stored[5]),
        .drive    (segment_out_six)
    );

endmodule // slg_game

// one segment: a selector stage, its memory bit and the segment drive
module slg_seg_cell
#(
    parameter [0:0] SEL_INIT = 1'b0, // selector stage in reset
    parameter [0:0] MEM_INIT = 1'b0  // memory bit in reset
)
(
    // clock and reset
    input  wire clk,
    input  wire sys_rst,
    // selector ring
    input  wire ring_in,
    output wire ring_out,
    // pick and display control
    input  wire take,
    input  wire blank,
    output wire stored,
    output wire drive
);

    reg  sel_q; // selector stage
    reg  mem_q; // picked flag
    wire mem_d; // next picked flag

    // selector stage copies its neighbour every rising edge
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sel_q <= SEL_INIT;
        else
            sel_q <= ring_in;
    end

    // a pick while the cursor sits here lights the segment until the zero is won
    assign mem_d = mem_q | (take & sel_q);

    // memory bit, cleared only by reset
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mem_q <= MEM_INIT;
        else
            mem_q <= mem_d;
    end

    // ring, memory and drive out; dark once the zero is won
    assign ring_out = sel_q;
    assign stored   = mem_q;
    assign drive    = ~blank & (mem_q | sel_q);

endmodule // slg_seg_cell

// file: core/slg_regs.vh
`ifndef SLG_REGS_VH
`define SLG_REGS_VH

// segment count shared by selector and selection memory
`define SLG_WIDTH     6
// selector reset value: one active bit on the first segment
`define SLG_SEL_RESET 6'h01
// selection memory reset value: nothing lit
`define SLG_MEM_RESET 6'h00
// completed flag reset value: game not won
`define SLG_DONE_RESET 1'b0
// pattern of a complete zero
`define SLG_ALL_LIT   6'h3F

`endif

// file: testbench/slg_player.sv
`timescale 1ns/1ps
// player flips the lever at the falling edge when asked
module slg_player(input wire clk, flip, output reg lever = 1'h0);
    always @(negedge clk) lever <= lever ^ flip;
endmodule // slg_player

// file: testbench/slg_properties.sv
`timescale 1ns/1ps
// port checks of the game
module slg_chk(input wire clk, sys_rst, segment_out_one, segment_out_two,
    segment_out_three, segment_out_four, segment_out_five, segment_out_six, dot_segment_out);
    wire [5:0] s = {segment_out_six, segment_out_five, segment_out_four, segment_out_three,
        segment_out_two, segment_out_one};
    wire d = dot_segment_out;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_dot_blank: assert property (d |-> !s) else $error("lit with dot");
    a_dot_holds: assert property (d |=> d) else $error("dot lost");
    a_done_full: assert property ($rose(d) |-> $past(s) == 6'h3F) else $error("early dot");
    a_full_done: assert property (!d && s == 6'h3F ##1 s == 6'h3F |=> d) else $error("no dot");
    a_first_step: assert property ($fell(sys_rst) |-> s == 6'h01 && !d ##1 s == 6'h02)
        else $error("bad start");
    a_lit_keeps: assert property (!d |=> d || $countones(s) + 1 >= $countones($past(s)))
        else $error("lit lost");
    a_grow_one: assert property (!d |=> $countones(s) <= $countones($past(s)) + 1)
        else $error("jump");
endmodule // slg_chk
bind slg_game slg_chk i_slg_chk(.*);

// file: testbench/slg_tb.sv
`timescale 1ns/1ps
module testbench;
    reg clk = 0, sys_rst = 1, flip = 0, d;
    reg [5:0] sel, mem;
    reg [2:0] q;
    wire select;
    wire [6:0] y;
    integer err_total = 0, checked = 0, cyc = 0;
    initial forever #10 clk = ~clk;
    slg_player i_slg_player(.clk(clk), .flip(flip), .lever(select));
    slg_game i_slg_game(.clk(clk), .sys_rst(sys_rst), .select(select), .segment_out_one(y[0]),
        .segment_out_two(y[1]), .segment_out_three(y[2]), .segment_out_four(y[3]),
        .segment_out_five(y[4]), .segment_out_six(y[5]), .dot_segment_out(y[6]));
    function [6:0] want;
        want = {d, d ? 6'h00 : mem | sel};
    endfunction
    // reference synchroniser, runs through reset
    always @(posedge clk) q <= {q[1:0], select};
    // reference: edge pick, memory, done, rotation
    always @(posedge clk or posedge sys_rst)
        if (sys_rst) {d, mem, sel} <= 13'h0001;
        else
        begin
            mem <= d ? mem : mem | (q[1] ^ q[2] ? sel : 6'h00);
            d <= d | (mem == 6'h3F);
            sel <= {sel[4:0], sel[5]};
        end
    task miss(input [6:0] e);
        err_total = err_total + 1;
        $display("Error display exp %h got %h", e, y);
    endtask
    // compare every cycle out of reset at the falling edge
    always @(negedge clk)
        if (!sys_rst)
        begin
            checked = checked + 1;
            if (y !== want()) miss(want());
        end
    task run(input integer n, m);
        repeat (n) @(negedge clk) flip <= m > 1 || m && $urandom % 4 == 0;
        $display("test mode %0d done", m);
    endtask
    task conclude(input integer hang);
        err_total = err_total + hang;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc > 400) conclude(1);
    end
    initial
    begin
        cyc = $urandom(5074);
        cyc = 0;
        repeat (20) @(negedge clk);
        sys_rst <= 0;
        run(12, 0);
        run(60, 1);
        // switch left high through a shorter reset: no pick may follow
        run(2, 0);
        run(1, select ? 0 : 2);
        run(2, 0);
        sys_rst <= 1;
        repeat (3) @(negedge clk);
        sys_rst <= 0;
        run(6, 0);
        run(20, 2);
        run(9, 1);
        if (y !== 7'h40) miss(7'h40);
        conclude(0);
    end
endmodule // testbench
